// ### core/scps_power_ctrl.v
// Purpose: Command and clock-enable state logic of a two-bank synchronous DRAM.
// Assumes: Memory controller drives all pins synchronous to ref_clk.
// Notes: Data path and burst sequencing beyond a length counter are absent.
//
// Overview of operation
// (R1) All pins are sampled only on the rising clock edge.
// (R2) Mode set loads the twelve address levels; only with both banks idle.
// (R3) Refresh uses an internal row counter and ignores address pins.
// (R4) In self-refresh only clock enable is looked at; the code also needs a no-op on the command pins to leave it.
// (R5) Controller activates only idle banks, reads or writes only active ones.
// (R6) Burst stop acts only when burst length is full page.
// (R7) Bank commands are judged by the bank chosen by the bank select bit.
// (R8) Controller waits the bank-to-bank activate delay.
// (R9) Controller waits the active-to-precharge time before precharge.
// (R10) Auto-precharge closes the bank as soon as its burst ends; the code skips this for full-page bursts, which leave the bank open.
// (R11) Controller waits activate-to-column delay after an activate.
// (R12) Clock enable falling with both idle gives power-down, or self-refresh.
// (R13) Self-refresh entry only with both banks idle.
// (R14) Clock enable rising in self-refresh starts recovery; idle after row cycle.
// (R15) Clock enable low in recovery with no-op gives power-down next cycle.
// (R16) Clock enable rising ends power-down to idle; low keeps it.
// (R17) Elsewhere clock enable low suspends, high resumes, from next cycle.
// (R18) With both idle, strobes decode activate, precharge, refresh, mode set.
// (R19) Controller leaves two cycles after a mode set.
// (R20) A copy of last cycle's clock enable selects state transitions.
`timescale 1ns/1ps
`include "scps_defines.vh"
module scps_power_ctrl #(
  parameter ROW_W = 11
) (
  input wire ref_clk,
  input wire resetn,
  input wire clkEn,
  input wire csN,
  input wire rasN,
  input wire casN,
  input wire weN,
  input wire [`SCPS_OPCODE_W-1:0] addr,
  output reg [`SCPS_OPCODE_W-1:0] opCode,
  output reg [1:0] bankActive,
  output reg [1:0] bankBursting,
  output reg [ROW_W-1:0] refreshRow,
  output reg refreshPulse,
  output reg inPowerDown,
  output reg inSelfRefresh,
  output reg inRecovery,
  output reg clockSuspended,
  output reg illegalCmd
);
  localparam integer TRC_CYC = (`SCPS_TRC_NS * `SCPS_CLK_MHZ + 999) / 1000;
  localparam [4:0] ST_RUN = 5'h01;
  localparam [4:0] ST_PD = 5'h02;
  localparam [4:0] ST_SREF = 5'h04;
  localparam [4:0] ST_REC = 5'h08;
  localparam [4:0] ST_SUSP = 5'h10;

  reg rstMeta_q, rstSync_q;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  wire rstN = rstSync_q;

  wire isNop, isBst, isRd, isWr, isAct, isPre, isRef, isMrs;
  scps_cmd_decode uDec (
    .csN(csN),
    .rasN(rasN),
    .casN(casN),
    .weN(weN),
    .isNop(isNop),
    .isBurstStop(isBst),
    .isRead(isRd),
    .isWrite(isWr),
    .isActivate(isAct),
    .isPrecharge(isPre),
    .isRefresh(isRef),
    .isModeSet(isMrs)
  );

  reg [4:0] state_q, state_d;
  reg clkEnPrev_q; // (R20)
  reg [7:0] recCnt_q;
  reg [1:0] mrsWait_q;
  reg [1:0] autoPre_q;
  reg [`SCPS_BURST_CNT_W-1:0] burstCnt_q [0:1];

  wire bankSel = addr[`SCPS_BANK_BIT]; // (R7)
  wire bothIdle = (bankActive == 2'h0) && (bankBursting == 2'h0);
  wire fullPage = (opCode[`SCPS_BL_LSB +: `SCPS_BL_W] == `SCPS_BL_FULLPAGE);
  wire [`SCPS_BURST_CNT_W-1:0] burstLen = fullPage ? `SCPS_FULLPAGE_LEN :
    ({{(`SCPS_BURST_CNT_W-1){1'b0}}, 1'b1} << opCode[`SCPS_BL_LSB +: 2]);
  wire running = (state_q == ST_RUN);
  wire cmdLive = running && clkEnPrev_q && clkEn; // (R1)
  wire ceFall = clkEnPrev_q && !clkEn;
  wire ceRise = !clkEnPrev_q && clkEn;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (ceFall && bothIdle)
          state_d = (isRef) ? ST_SREF : ST_PD; // (R12) (R13)
        else if (ceFall)
          state_d = ST_SUSP; // (R17)
      end
      ST_PD: if (clkEn) state_d = ST_RUN; // (R16)
      ST_SREF: if (ceRise && isNop) state_d = ST_REC; // (R4) (R14)
      ST_REC: begin
        if (ceFall && isNop) state_d = ST_PD; // (R15)
        else if (clkEn && recCnt_q == 8'h00) state_d = ST_RUN; // (R14)
      end
      ST_SUSP: if (clkEn) state_d = ST_RUN; // (R17)
      default: state_d = ST_RUN;
    endcase
  end

  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      state_q <= ST_RUN;
      clkEnPrev_q <= 1'b1;
      recCnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      clkEnPrev_q <= clkEn; // (R20)
      if (state_q != ST_REC && state_d == ST_REC)
        recCnt_q <= TRC_CYC[7:0]; // (R14)
      else if (recCnt_q != 8'h00 && clkEn)
        recCnt_q <= recCnt_q - 8'h01;
    end
  end

  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      opCode <= `SCPS_OPCODE_RST;
      refreshRow <= {ROW_W{1'b0}};
      refreshPulse <= 1'b0;
      mrsWait_q <= 2'h0;
      illegalCmd <= 1'b0;
    end else begin
      refreshPulse <= 1'b0;
      illegalCmd <= 1'b0;
      if (mrsWait_q != 2'h0 && clkEn)
        mrsWait_q <= mrsWait_q - 2'h1;
      if (cmdLive && isMrs) begin
        if (bothIdle && mrsWait_q == 2'h0) begin
          opCode <= addr; // (R2)
          mrsWait_q <= `SCPS_TMRD_CYC;
        end else
          illegalCmd <= 1'b1; // (R2) (R19)
      end
      if (cmdLive && isRef) begin
        if (bothIdle) begin
          refreshRow <= refreshRow + {{(ROW_W-1){1'b0}}, 1'b1}; // (R3)
          refreshPulse <= 1'b1;
        end else
          illegalCmd <= 1'b1;
      end
      if (state_q == ST_SREF && state_d == ST_SREF && !clkEn)
        refreshRow <= refreshRow + {{(ROW_W-1){1'b0}}, 1'b1}; // (R3)
      if (cmdLive && isAct && bankActive[bankSel])
        illegalCmd <= 1'b1; // (R5) (R7)
      if (cmdLive && (isRd || isWr) && !bankActive[bankSel])
        illegalCmd <= 1'b1; // (R5) (R7)
      if (state_q == ST_REC && clkEn && !isNop)
        illegalCmd <= 1'b1; // (R14)
    end
  end

  genvar b;
  generate
    for (b = 0; b < 2; b = b + 1) begin : gBank
      wire sel = (bankSel == (b != 0));
      wire bstDone = bankBursting[b] && !fullPage && burstCnt_q[b] == 9'h001;
      always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
          bankActive[b] <= 1'b0;
          bankBursting[b] <= 1'b0;
          autoPre_q[b] <= 1'b0;
          burstCnt_q[b] <= {`SCPS_BURST_CNT_W{1'b0}};
        end else if (running && clkEnPrev_q) begin
          if (bankBursting[b] && burstCnt_q[b] != 9'h000)
            burstCnt_q[b] <= burstCnt_q[b] - 9'h001;
          if (bstDone) begin
            bankBursting[b] <= 1'b0;
            if (autoPre_q[b]) begin
              bankActive[b] <= 1'b0; // (R10)
              autoPre_q[b] <= 1'b0;
            end
          end
          if (clkEn) begin
            if (isAct && sel && !bankActive[b])
              bankActive[b] <= 1'b1; // (R7) (R18)
            if ((isRd || isWr) && sel && bankActive[b]) begin
              bankBursting[b] <= 1'b1;
              autoPre_q[b] <= addr[`SCPS_AP_BIT]; // (R10)
              burstCnt_q[b] <= burstLen;
            end
            if (isBst && fullPage && bankBursting[b])
              bankBursting[b] <= 1'b0; // (R6)
            if (isPre && (addr[`SCPS_AP_BIT] || sel)) begin
              bankActive[b] <= 1'b0; // (R7) (R18)
              bankBursting[b] <= 1'b0;
              autoPre_q[b] <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  always @* begin
    inPowerDown = (state_q == ST_PD);
    inSelfRefresh = (state_q == ST_SREF);
    inRecovery = (state_q == ST_REC);
    clockSuspended = (state_q == ST_SUSP);
  end
endmodule // scps_power_ctrl

// ### core/scps_defines.vh
// Purpose: Shared constants for the clock-enable and power state logic.
// Assumes: Plain Verilog-2005 tools.
// Notes: Included by bare name.
`ifndef SCPS_DEFINES_VH
`define SCPS_DEFINES_VH
`define SCPS_CLK_MHZ 40
`define SCPS_TRC_NS 70
`define SCPS_TMRD_CYC 2'h2
`define SCPS_OPCODE_W 12
`define SCPS_BANK_BIT 11
`define SCPS_BL_LSB 0
`define SCPS_BL_W 3
`define SCPS_BL_FULLPAGE 3'h7
`define SCPS_BURST_CNT_W 9
`define SCPS_FULLPAGE_LEN 9'h100
`define SCPS_OPCODE_RST 12'h000
`define SCPS_AP_BIT 10
`endif

// ### core/scps_cmd_decode.v
// Purpose: Decode of chip select, row strobe, column strobe and write enable.
// Assumes: Command pins are sampled by the caller on the rising clock edge.
// Notes: Pure combinational decode.
`timescale 1ns/1ps
module scps_cmd_decode (
  input wire csN,
  input wire rasN,
  input wire casN,
  input wire weN,
  output wire isNop,
  output wire isBurstStop,
  output wire isRead,
  output wire isWrite,
  output wire isActivate,
  output wire isPrecharge,
  output wire isRefresh,
  output wire isModeSet
);
  wire [3:0] cmd = {csN, rasN, casN, weN};
  // A deselect counts as no-operation.
  assign isNop = csN | (cmd == 4'h7);
  assign isBurstStop = (cmd == 4'h6);
  assign isRead = (cmd == 4'h5);
  assign isWrite = (cmd == 4'h4);
  assign isActivate = (cmd == 4'h3); // (R18)
  assign isPrecharge = (cmd == 4'h2); // (R18)
  assign isRefresh = (cmd == 4'h1); // (R18)
  assign isModeSet = (cmd == 4'h0); // (R18)
endmodule // scps_cmd_decode

// ### tb/scps_ctrl_model.sv
// Purpose: Memory controller model that drives the command pins.
// Assumes: Pins change 1 ns after the rising edge.
// Notes: Deselected cycles drive inverted address levels.
`timescale 1ns/1ps
`include "scps_defines.vh"
module scps_ctrl_model (
  input wire ref_clk,
  output reg clkEn,
  output reg csN,
  output reg rasN,
  output reg casN,
  output reg weN,
  output reg [`SCPS_OPCODE_W-1:0] addr
);
  initial {clkEn, csN, rasN, casN, weN, addr} = {5'h1F, 12'h000};
  // Idle cycles first keep bank timing and mode set spacing.
  task drive(input ce, input [3:0] c, input [11:0] a, input int g);
    repeat (g) @(posedge ref_clk);
    #1 {clkEn, csN, rasN, casN, weN, addr} = {ce, c, a};
    @(posedge ref_clk);
    #1 {csN, rasN, casN, weN, addr} = {4'hF, ~a};
  endtask
endmodule // scps_ctrl_model

// ### tb/scps_power_ctrl_asserts.sv
// Purpose: Concurrent checks on the power state ports.
// Assumes: Bound to every power state block.
// Notes: One clock domain.
`timescale 1ns/1ps
module scps_power_ctrl_asserts #(
  parameter ROW_W = 11
) (
  input wire ref_clk,
  input wire resetn,
  input wire clkEn,
  input wire csN,
  input wire rasN,
  input wire casN,
  input wire weN,
  input wire [11:0] addr,
  input wire [11:0] opCode,
  input wire [1:0] bankActive,
  input wire [ROW_W-1:0] refreshRow,
  input wire refreshPulse,
  input wire inPowerDown,
  input wire inSelfRefresh,
  input wire inRecovery,
  input wire clockSuspended
);
  wire [3:0] c = {csN, rasN, casN, weN};
  wire run = !(inPowerDown | inSelfRefresh | inRecovery | clockSuspended);
  wire idle = run && bankActive == 2'h0;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  chk_sr_entry: assert property (idle && $past(clkEn) && !clkEn && c == 4'h1
    |=> inSelfRefresh) else $error("self-refresh not entered");
  chk_pd_entry: assert property (idle && $past(clkEn) && !clkEn && csN
    |=> inPowerDown) else $error("power-down not entered");
  chk_sr_hold: assert property (inSelfRefresh && !clkEn
    |=> inSelfRefresh && $stable(opCode) && bankActive == 2'h0) else $error("pins not ignored");
  chk_sr_exit: assert property (inSelfRefresh && clkEn && csN |=> inRecovery)
    else $error("recovery not started");
  chk_rec_pd: assert property (inRecovery && $past(clkEn) && !clkEn && csN
    |=> inPowerDown) else $error("recovery did not power down");
  chk_pd_exit: assert property (inPowerDown |=> inPowerDown == !$past(clkEn))
    else $error("power-down exit wrong");
  chk_clk_suspend: assert property (run && bankActive != 2'h0 && $past(clkEn) && !clkEn
    |=> ##[0:1] clockSuspended) else $error("suspend missing");
  chk_ref_pulse: assert property (idle && $past(clkEn) && clkEn && c == 4'h1
    |=> refreshPulse && refreshRow != $past(refreshRow)) else $error("refresh missing");
  chk_mode_load: assert property (idle && $past(clkEn) && clkEn && c == 4'h0
    |=> opCode == $past(addr)) else $error("opcode not loaded");
  chk_act_bank: assert property (run && $past(clkEn) && clkEn && c == 4'h3
    && !bankActive[addr[11]] |=> bankActive[$past(addr[11])]) else $error("bank not opened");
endmodule // scps_power_ctrl_asserts
bind scps_power_ctrl scps_power_ctrl_asserts #(.ROW_W(ROW_W)) i_scps_power_ctrl_asserts (
  .ref_clk(ref_clk),
  .resetn(resetn),
  .clkEn(clkEn),
  .csN(csN),
  .rasN(rasN),
  .casN(casN),
  .weN(weN),
  .addr(addr),
  .opCode(opCode),
  .bankActive(bankActive),
  .refreshRow(refreshRow),
  .refreshPulse(refreshPulse),
  .inPowerDown(inPowerDown),
  .inSelfRefresh(inSelfRefresh),
  .inRecovery(inRecovery),
  .clockSuspended(clockSuspended)
);

// ### tb/scps_power_ctrl_tb_top.sv
// Purpose: Directed scenarios for the power state block.
// Assumes: The model drives pins 1 ns after each rising edge.
// Notes: Each task judges its own outcome.
`timescale 1ns/1ps
module scps_power_ctrl_tb_top;
  reg ref_clk = 1'b0;
  reg resetn = 1'b0;
  wire clkEn, csN, rasN, casN, weN, refreshPulse, illegalCmd;
  wire inPowerDown, inSelfRefresh, inRecovery, clockSuspended;
  wire [11:0] addr, opCode;
  wire [1:0] bankActive, bankBursting;
  wire [10:0] refreshRow;
  reg [10:0] row;
  integer mismatches = 0;
  integer cmp_count = 0;
  scps_ctrl_model i_scps_ctrl_model (
    .ref_clk(ref_clk),
    .clkEn(clkEn),
    .csN(csN),
    .rasN(rasN),
    .casN(casN),
    .weN(weN),
    .addr(addr)
  );
  scps_power_ctrl #(.ROW_W(11)) i_scps_power_ctrl (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .csN(csN),
    .rasN(rasN),
    .casN(casN),
    .weN(weN),
    .addr(addr),
    .opCode(opCode),
    .bankActive(bankActive),
    .bankBursting(bankBursting),
    .refreshRow(refreshRow),
    .refreshPulse(refreshPulse),
    .inPowerDown(inPowerDown),
    .inSelfRefresh(inSelfRefresh),
    .inRecovery(inRecovery),
    .clockSuspended(clockSuspended),
    .illegalCmd(illegalCmd)
  );
  initial forever #12.5 ref_clk = ~ref_clk;
  task d(input ce, input [3:0] c, input [11:0] a, input int g = 4);
    i_scps_ctrl_model.drive(ce, c, a, g);
  endtask
  task tick;
    @(posedge ref_clk);
    #2;
  endtask
  task chk(input string nm, input [11:0] exp, input [11:0] got);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("MISMATCH %0s expected %h seen %h", nm, exp, got);
    end
  endtask
  task t_mode;
    d(1, 4'h0, 12'h020);
    chk("opCode", 12'h020, opCode);
    $display("t_mode ends");
  endtask
  task t_ref;
    row = refreshRow;
    d(1, 4'h1, 12'hFFF);
    chk("refreshPulse", 1, refreshPulse);
    chk("rowMoved", 1, refreshRow != row);
    $display("t_ref ends");
  endtask
  task t_bank;
    d(1, 4'h3, 12'h800);
    chk("bankActive", 2'h2, bankActive);
    d(0, 4'hF, 0);
    tick;
    chk("suspended", 1, clockSuspended);
    d(1, 4'hF, 0);
    tick;
    chk("suspended", 0, clockSuspended);
    d(1, 4'h3, 12'h000);
    d(1, 4'h5, 12'h400);
    chk("bursting", 2'h1, bankBursting);
    tick;
    chk("bankActive", 2'h2, bankActive);
    d(1, 4'h2, 12'h400);
    chk("bankActive", 2'h0, bankActive);
    $display("t_bank ends");
  endtask
  task t_sr;
    d(0, 4'h1, 0);
    chk("selfRefresh", 1, inSelfRefresh);
    d(0, 4'h3, 12'hFFF);
    chk("bankActive", 2'h0, bankActive);
    d(1, 4'hF, 0);
    chk("recovery", 1, inRecovery);
    repeat (4) tick;
    chk("recovery", 0, inRecovery);
    d(0, 4'h1, 0);
    d(1, 4'hF, 0, 0);
    d(0, 4'hF, 0, 0);
    tick;
    chk("powerDown", 1, inPowerDown);
    d(1, 4'hF, 0);
    chk("powerDown", 0, inPowerDown);
    $display("t_sr ends");
  endtask
  task t_pd;
    d(0, 4'hF, 0);
    chk("powerDown", 1, inPowerDown);
    d(0, 4'h3, 0);
    chk("powerDown", 1, inPowerDown);
    d(1, 4'hF, 0);
    chk("powerDown", 0, inPowerDown);
    $display("t_pd ends");
  endtask
  task t_cmd;
    d(1, 4'h0, 12'h007);
    d(1, 4'h0, 12'h007, 0);
    chk("illegalCmd", 1, illegalCmd);
    chk("opCode", 12'h007, opCode);
    d(1, 4'h5, 12'h000);
    chk("illegalCmd", 1, illegalCmd);
    d(1, 4'h3, 12'h000);
    d(1, 4'h3, 12'h000);
    chk("illegalCmd", 1, illegalCmd);
    d(1, 4'h5, 12'h000);
    repeat (4) tick;
    chk("bursting", 2'h1, bankBursting);
    d(1, 4'h6, 12'h000);
    chk("bursting", 2'h0, bankBursting);
    chk("illegalCmd", 0, illegalCmd);
    d(1, 4'h2, 12'h400);
    d(1, 4'h0, 12'h002);
    d(1, 4'h3, 12'h000);
    d(1, 4'h5, 12'h000);
    d(1, 4'h6, 12'h000, 0);
    chk("bursting", 2'h1, bankBursting);
    d(1, 4'h2, 12'h400);
    chk("bankActive", 2'h0, bankActive);
    $display("t_cmd ends");
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    #1 resetn = 1'b1;
    t_mode;
    t_ref;
    t_bank;
    t_sr;
    t_pd;
    t_cmd;
    end_of_test;
  end
  initial begin
    #20000;
    mismatches = mismatches + 1;
    end_of_test;
  end
endmodule // scps_power_ctrl_tb_top
